// ===== hdl/drive_status_pkg.sv
// Constants, types and register map of the drive status output selector
package drive_status_pkg;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_THRESH = 12'h004;
  localparam logic [11:0] OFS_MAX_FREQ = 12'h008;
  localparam logic [11:0] OFS_RATED_CUR = 12'h00c;
  localparam logic [11:0] OFS_RATED_PWR = 12'h010;
  localparam logic [11:0] OFS_SKIP_WIDTH = 12'h014;
  localparam logic [11:0] OFS_SKIP_CENTRE = 12'h018;
  localparam logic [11:0] OFS_VF_VOLT = 12'h01c;
  localparam logic [11:0] OFS_VF_FREQ = 12'h020;
  localparam logic [11:0] OFS_STATUS = 12'h024;
  localparam int unsigned NUM_CFG = 9;
  localparam logic [3:0] IDX_STATUS = 4'h9;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam logic [15:0] CTRL_RESET = 16'h0008;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [3:0] SEL_MAX = 4'hb;
  localparam logic [2:0] MAX_RESTARTS = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Output function codes
  localparam logic [3:0] SEL_RUNNING = 4'h0;
  localparam logic [3:0] SEL_HEALTHY = 4'h1;
  localparam logic [3:0] SEL_AT_TARGET = 4'h2;
  localparam logic [3:0] SEL_TRIPPED = 4'h3;
  localparam logic [3:0] SEL_FREQ_GE = 4'h4;
  localparam logic [3:0] SEL_CUR_GE = 4'h5;
  localparam logic [3:0] SEL_FREQ_LT = 4'h6;
  localparam logic [3:0] SEL_CUR_LT = 4'h7;
  localparam logic [3:0] SEL_AN_FREQ = 4'h8;
  localparam logic [3:0] SEL_AN_CUR = 4'h9;
  localparam logic [3:0] SEL_AN_PWR = 4'ha;
  localparam logic [3:0] SEL_AN_LOAD = 4'hb;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_TRIP = 2'b10,
    ST_LOCK = 2'b11
  } drive_state_t;

  typedef struct packed {
    logic auto_restart_five_attempts;
    logic auto_start_mode;
    logic [3:0] sel;
  } ctrl_t;

  typedef struct packed {
    logic run;
    logic fault;
    logic fault_reset;
  } pins_t;

endpackage

// ===== hdl/drive_status_output_select.sv
// Drive status output selector with skip band, start mode and restart logic
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Selector 1 drives output high while no fault is present and the drive is not tripped.
// - Selector 2 high when running and output frequency equals setpoint.
// - Selector 3 high while drive is tripped.
// - Selector 4 high when output frequency at or above threshold.
// - Selector 5 high when motor current at or above threshold.
// - Selector 6 high when output frequency below threshold.
// - Selector 7 high when motor current below threshold.
// - Selector 8 analog output frequency, full scale maximum frequency.
// - Selector 9 analog motor current, full scale twice rated current.
// - Selector 10 analog output power, full scale twice rated power.
// - Selector 11 analog load current, full scale twice rated current.
// - Selector resets to 8, the analog frequency output.
// - Skip width and centre registers, reset to zero meaning inactive.
// - Setpoint inside skip band holds output frequency fixed.
// - V/F adjustment voltage and frequency point, both reset to zero.
// - Edge mode: run input closed at reset does not start.
// - Auto-start mode: closed run input starts drive after reset.
// - Auto restart tries five times, then latches fault until reset.
module drive_status_output_select (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire drive_status_pkg::pins_t pins_i,
  input wire logic [15:0] setpoint_i,
  input wire logic [15:0] motor_cur_i,
  input wire logic [15:0] out_pwr_i,
  output logic run_o,
  output logic [15:0] freq_out_o,
  output logic dout_o,
  output logic analog_mode_o,
  output logic [15:0] aout_o,
  output logic [15:0] aout_full_o,
  output logic [15:0] vf_volt_o,
  output logic [15:0] vf_freq_o
);
  import drive_status_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pins_t meta_r, sync_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pins_i;
      sync_r <= meta_r;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [3:0] wr_idx_r, wr_idx_nxt;
  logic wr_ok_r, wr_ok_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [1:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_wr;
  logic [15:0] cfg_r [NUM_CFG];
  logic [15:0] status_w;
  ctrl_t ctrl;

  assign s_axi_awready_o = ~aw_held_r;
  assign s_axi_wready_o = ~w_held_r;
  assign s_axi_arready_o = ~rvalid_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;
  // Write commits once both halves are held and no answer is pending
  assign do_wr = aw_held_r & w_held_r & ~bvalid_r;

  // Channel bookkeeping; unmapped or misaligned words answer SLVERR
  always_comb begin
    logic [3:0] ri;
    ri = s_axi_araddr_i[5:2];
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    wr_idx_nxt = wr_idx_r;
    wr_ok_nxt = wr_ok_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r & ~s_axi_bready_i;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r & ~s_axi_rready_i;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid_i && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      wr_idx_nxt = s_axi_awaddr_i[5:2];
      // Status word is read-only, so writes to it are refused
      wr_ok_nxt = (s_axi_awaddr_i[11:6] == 6'h00) && (s_axi_awaddr_i[1:0] == 2'b00)
                  && (s_axi_awaddr_i[5:2] < IDX_STATUS);
    end
    if (s_axi_wvalid_i && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata_i[15:0];
      wstrb_nxt = s_axi_wstrb_i[1:0];
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok_r ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_arvalid_i && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = RESP_SLVERR;
      if (s_axi_araddr_i[11:6] == 6'h00 && s_axi_araddr_i[1:0] == 2'b00) begin
        if (ri < IDX_STATUS) begin
          rdata_nxt = {16'h0000, cfg_r[ri]};
          rresp_nxt = RESP_OKAY;
        end else if (ri == IDX_STATUS) begin
          rdata_nxt = {16'h0000, status_w};
          rresp_nxt = RESP_OKAY;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_idx_r <= 4'h0;
      wr_ok_r <= 1'b0;
      wdata_r <= 16'h0000;
      wstrb_r <= 2'b00;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      wr_idx_r <= wr_idx_nxt;
      wr_ok_r <= wr_ok_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Configuration words
  // ****************************************
  // word 0 resets to selector 8, the rest to zero
  for (genvar g = 0; g < NUM_CFG; g++) begin : g_cfg
    logic [15:0] nxt;
    always_comb begin
      nxt = cfg_r[g];
      if (do_wr && wr_ok_r && wr_idx_r == 4'(g)) begin
        for (int b = 0; b < 2; b++) begin
          if (wstrb_r[b]) begin
            nxt[8*b +: 8] = wdata_r[8*b +: 8];
          end
        end
        // Out-of-range selectors saturate at the last function
        if (g == 0 && nxt[3:0] > SEL_MAX) begin
          nxt[3:0] = SEL_MAX;
        end
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cfg_r[g] <= (g == 0) ? CTRL_RESET : CFG_RESET;
      end else begin
        cfg_r[g] <= nxt;
      end
    end
  end

  assign ctrl = ctrl_t'(cfg_r[0][5:0]);
  // V/F point handed straight to the voltage shaper
  assign vf_volt_o = cfg_r[7];
  assign vf_freq_o = cfg_r[8];

  // ****************************************
  // Start, trip and restart sequencing
  // ****************************************
  drive_state_t st_r, st_nxt;
  logic primed_r, primed_nxt, prev_r, prev_nxt;
  logic [1:0] warm_r, warm_nxt;
  logic [2:0] tries_r, tries_nxt;
  logic run_s, fault_s, freset_s, rise, tripped;

  assign run_s = sync_r.run;
  assign fault_s = sync_r.fault;
  assign freset_s = sync_r.fault_reset;
  // an edge counts only once a post-reset sample exists
  assign rise = primed_r & run_s & ~prev_r;
  assign tripped = (st_r == ST_TRIP) | (st_r == ST_LOCK);
  assign status_w = {9'h000, tries_r, st_r, fault_s, run_s};

  // synchroniser resets open, so its first closed sample is no edge
  always_comb begin
    st_nxt = st_r;
    tries_nxt = tries_r;
    warm_nxt = warm_r[1] ? warm_r : warm_r + 2'h1;
    primed_nxt = warm_r[1];
    prev_nxt = run_s;
    case (st_r)
      ST_IDLE: begin
        if (fault_s) begin
          st_nxt = ST_TRIP;
        // edge start unless auto-start accepts the level
        end else if (run_s && (rise || ctrl.auto_start_mode)) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // trip after the fifth restart latches hard
        if (fault_s) begin
          st_nxt = (tries_r == MAX_RESTARTS) ? ST_LOCK : ST_TRIP;
        end else if (!run_s) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_TRIP: begin
        if (freset_s) begin
          st_nxt = ST_IDLE;
        // restart attempt once the fault has cleared
        end else if (!fault_s && run_s && ctrl.auto_restart_five_attempts) begin
          st_nxt = ST_RUN;
          tries_nxt = tries_r + 3'h1;
        end
      end
      ST_LOCK: begin
        if (freset_s) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Fault reset acts as a reset: a fresh closure is needed again
    if (freset_s && tripped) begin
      tries_nxt = 3'h0;
      primed_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      tries_r <= 3'h0;
      warm_r <= 2'h0;
      primed_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tries_r <= tries_nxt;
      warm_r <= warm_nxt;
      primed_r <= primed_nxt;
      prev_r <= prev_nxt;
    end
  end

  // ****************************************
  // Frequency command and output selection
  // ****************************************
  logic [15:0] cmd_r, cmd_nxt, fout_r, fout_nxt, aout_r, aout_nxt, full_r, full_nxt;
  logic dout_r, dout_nxt, amode_r, amode_nxt;
  logic [16:0] band_lo, band_hi;
  logic in_band;

  // band centred on the centre point, zero width disables
  assign band_lo = {1'b0, cfg_r[6]} - {2'b00, cfg_r[5][15:1]};
  assign band_hi = {1'b0, cfg_r[6]} + {2'b00, cfg_r[5][15:1]};
  assign in_band = (cfg_r[5] != 16'h0000) && ({1'b0, setpoint_i} <= band_hi)
                   && (band_lo[16] || {1'b0, setpoint_i} >= band_lo);

  always_comb begin
    logic [15:0] val;
    val = 16'h0000;
    // inside the band the command stays where it was
    cmd_nxt = in_band ? cmd_r : ((setpoint_i > cfg_r[2]) ? cfg_r[2] : setpoint_i);
    fout_nxt = (st_r == ST_RUN) ? cmd_r : 16'h0000;
    dout_nxt = 1'b0;
    amode_nxt = ctrl.sel >= SEL_AN_FREQ;
    full_nxt = 16'h0000;
    case (ctrl.sel)
      SEL_RUNNING: dout_nxt = (st_r == ST_RUN);
      SEL_HEALTHY: dout_nxt = ~fault_s & ~tripped;
      SEL_AT_TARGET: dout_nxt = (st_r == ST_RUN) && (fout_r == setpoint_i);
      SEL_TRIPPED: dout_nxt = tripped;
      SEL_FREQ_GE: dout_nxt = fout_r >= cfg_r[1];
      SEL_CUR_GE: dout_nxt = motor_cur_i >= cfg_r[1];
      SEL_FREQ_LT: dout_nxt = fout_r < cfg_r[1];
      SEL_CUR_LT: dout_nxt = motor_cur_i < cfg_r[1];
      SEL_AN_FREQ: begin
        val = fout_r;
        full_nxt = cfg_r[2];
      end
      SEL_AN_CUR, SEL_AN_LOAD: begin
        val = motor_cur_i;
        full_nxt = {cfg_r[3][14:0], 1'b0};
      end
      SEL_AN_PWR: begin
        val = out_pwr_i;
        full_nxt = {cfg_r[4][14:0], 1'b0};
      end
      default: dout_nxt = 1'b0;
    endcase
    // Clamp so the analog stage never sees more than full scale
    aout_nxt = (val > full_nxt) ? full_nxt : val;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_r <= 16'h0000;
      fout_r <= 16'h0000;
      dout_r <= 1'b0;
      amode_r <= 1'b0;
      aout_r <= 16'h0000;
      full_r <= 16'h0000;
    end else begin
      cmd_r <= cmd_nxt;
      fout_r <= fout_nxt;
      dout_r <= dout_nxt;
      amode_r <= amode_nxt;
      aout_r <= aout_nxt;
      full_r <= full_nxt;
    end
  end

  assign run_o = (st_r == ST_RUN);
  assign freq_out_o = fout_r;
  assign dout_o = dout_r;
  assign analog_mode_o = amode_r;
  assign aout_o = aout_r;
  assign aout_full_o = full_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fresh_close;
    (primed_r && !run_s) ##1 (run_s && st_r == ST_IDLE && !fault_s);
  endsequence

  property p_run_out;
    ctrl.sel == SEL_RUNNING && $stable(ctrl.sel) |=> dout_r == $past(st_r == ST_RUN);
  endproperty
  a_run_out: assert property (p_run_out) else $error("running output wrong");
  property p_trip_out;
    ctrl.sel == SEL_TRIPPED && tripped && $stable(ctrl.sel) |=> dout_r;
  endproperty
  a_trip_out: assert property (p_trip_out) else $error("tripped output low");
  property p_freq_ge;
    ctrl.sel == SEL_FREQ_GE && fout_r >= cfg_r[1] |=> dout_r;
  endproperty
  a_freq_ge: assert property (p_freq_ge) else $error("freq limit output low");
  property p_freq_lt;
    ctrl.sel == SEL_FREQ_LT && fout_r >= cfg_r[1] |=> !dout_r;
  endproperty
  a_freq_lt: assert property (p_freq_lt) else $error("freq below output high");
  property p_an_freq;
    ctrl.sel == SEL_AN_FREQ |=> amode_r && full_r == $past(cfg_r[2]);
  endproperty
  a_an_freq: assert property (p_an_freq) else $error("analog frequency wrong");
  property p_sel_range;
    ctrl.sel <= SEL_MAX;
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("selector out of range");
  property p_skip_hold;
    in_band |=> cmd_r == $past(cmd_r);
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip band not held");
  property p_edge_need;
    st_r == ST_IDLE && !primed_r && !ctrl.auto_start_mode |=> st_r != ST_RUN;
  endproperty
  a_edge_need: assert property (p_edge_need) else $error("started without edge");
  property p_lock_hold;
    st_r == ST_LOCK && !freset_s |=> st_r == ST_LOCK && tries_r <= MAX_RESTARTS;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock released");
  property p_fresh_start;
    s_fresh_close |=> st_r == ST_RUN;
  endproperty
  a_fresh_start: assert property (p_fresh_start) else $error("edge not started");

endmodule
`default_nettype wire

// ===== testbench/drive_plant_model.sv
// Far-side plant model: run, fault and reset contacts plus load feedback
`timescale 1ns/1ps
`default_nettype none
module drive_plant_model (
  input wire logic clk_i,
  input wire logic run_req_i,
  input wire logic fault_req_i,
  input wire logic clr_req_i,
  input wire logic [15:0] cur_req_i,
  input wire logic [15:0] pwr_req_i,
  output var drive_status_pkg::pins_t pins_o,
  output logic [15:0] motor_cur_o,
  output logic [15:0] out_pwr_o
);
  import drive_status_pkg::*;
  // Contacts open at power-on, so no start is pending
  initial begin
    pins_o = '0;
    motor_cur_o = '0;
    out_pwr_o = '0;
  end
  // Contacts move a cycle late, as a slow plant would
  always @(posedge clk_i) begin
    pins_o <= {run_req_i, fault_req_i, clr_req_i};
    motor_cur_o <= cur_req_i;
    out_pwr_o <= pwr_req_i;
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the drive status output selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  import drive_status_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_i = 0;
  logic rst_n_i = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, run_o, dout, amode;
  logic [1:0] bresp, rresp;
  logic run_q = 0, flt_q = 0, clr_q = 0;
  logic [15:0] sp = 0, cur_q = 0, pwr_q = 0, mcur, opwr, fout, aout, afull, vfv, vff;
  pins_t pins;
  int fail_count = 0, n_checks = 0, mx, rc, rp, th, s, c, p;
  int sk_sp[6] = '{300, 500, 600, 550, 460, 449};
  int sk_ex[6] = '{300, 300, 600, 600, 600, 449};

  drive_plant_model i_drive_plant_model (.clk_i(clk_i), .run_req_i(run_q),
    .fault_req_i(flt_q), .clr_req_i(clr_q), .cur_req_i(cur_q), .pwr_req_i(pwr_q),
    .pins_o(pins), .motor_cur_o(mcur), .out_pwr_o(opwr));

  drive_status_output_select i_drive_status_output_select (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pins_i(pins), .setpoint_i(sp), .motor_cur_i(mcur), .out_pwr_i(opwr),
    .run_o(run_o), .freq_out_o(fout), .dout_o(dout), .analog_mode_o(amode),
    .aout_o(aout), .aout_full_o(afull), .vf_volt_o(vfv), .vf_freq_o(vff));

  // 10 MHz clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // ****************************************
  // Tasks and reference model
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Ready is sampled mid-cycle; it only moves on rising edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw, v;
    logic [1:0] r;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge clk_i);
      ga = awvalid & awready;
      gw = wvalid & wready;
      v = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (ga) awvalid <= 0;
      if (gw) wvalid <= 0;
    end while (v !== 1'b1);
    bready <= 0;
    chk("bresp", r, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic g, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clk_i);
      g = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (g) arvalid <= 0;
    end while (v !== 1'b1);
    rready <= 0;
    chk("rresp", r, er);
    chk("rdata", d, ed);
  endtask

  // Digital status with the drive running and healthy
  function automatic logic edout(int sel);
    int f;
    f = (s > mx) ? mx : s;
    case (sel)
      0, 1: return 1;
      2: return f == s;
      4: return f >= th;
      5: return c >= th;
      6: return f < th;
      7: return c < th;
      default: return 0;
    endcase
  endfunction

  // Doubled ratings truncate to 16 bits, as the port width forces
  function automatic int efull(int sel);
    if (sel == 8) return mx;
    return (sel == 10) ? (2 * rp) & 16'hffff : (2 * rc) & 16'hffff;
  endfunction

  function automatic int eaout(int sel);
    int v;
    v = (sel == 8) ? ((s > mx) ? mx : s) : (sel == 10) ? p : c;
    return (v > efull(sel)) ? efull(sel) : v;
  endfunction

  // Hang guard, far beyond the expected several hundred cycles
  initial begin
    #(20000 * 100);
    fail_count++;
    stop_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(32'hf46ebce5));
    wt(4);
    rst_n_i <= 1;
    rd(OFS_CTRL, 32'h8, RESP_OKAY);
    for (int i = 1; i < 9; i++) rd(12'(4 * i), 32'h0, RESP_OKAY);
    rd(12'h028, 32'h0, RESP_SLVERR);
    wr(OFS_STATUS, 32'h1, RESP_SLVERR);
    wr(OFS_CTRL, 32'hf, RESP_OKAY);
    rd(OFS_CTRL, 32'hb, RESP_OKAY);
    mx = 1000;
    rc = 200;
    rp = 300;
    wr(OFS_MAX_FREQ, 32'(mx), RESP_OKAY);
    wr(OFS_RATED_CUR, 32'(rc), RESP_OKAY);
    wr(OFS_RATED_PWR, 32'(rp), RESP_OKAY);
    wr(OFS_VF_VOLT, 32'h123, RESP_OKAY);
    wr(OFS_VF_FREQ, 32'h45, RESP_OKAY);
    chk("vf_volt", vfv, 32'h123);
    chk("vf_freq", vff, 32'h45);
    run_q <= 1;
    wt(8);
    chk("run", run_o, 1);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      th = $urandom_range(0, 999);
      s = (k == 0) ? th : $urandom_range(0, 1199);
      c = (k == 1) ? th : $urandom_range(0, 999);
      wr(OFS_THRESH, 32'(th), RESP_OKAY);
      sp <= 16'(s);
      cur_q <= 16'(c);
      for (int sel = 0; sel < 8; sel++) begin
        wr(OFS_CTRL, 32'(sel), RESP_OKAY);
        wt(5);
        chk("dout", dout, edout(sel));
        chk("amode", amode, 0);
      end
    end
    $display("test digital done");
    for (int sel = 8; sel < 12; sel++) begin
      s = $urandom_range(0, 1199);
      c = $urandom_range(0, 500);
      p = $urandom_range(0, 700);
      sp <= 16'(s);
      cur_q <= 16'(c);
      pwr_q <= 16'(p);
      wr(OFS_CTRL, 32'(sel), RESP_OKAY);
      wt(5);
      chk("amode", amode, 1);
      chk("afull", afull, 32'(efull(sel)));
      chk("aout", aout, 32'(eaout(sel)));
    end
    $display("test analog done");
    wr(OFS_SKIP_WIDTH, 32'd100, RESP_OKAY);
    wr(OFS_SKIP_CENTRE, 32'd500, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      sp <= 16'(sk_sp[i]);
      wt(5);
      chk("freq_out", fout, 32'(sk_ex[i]));
    end
    wr(OFS_SKIP_WIDTH, 32'd0, RESP_OKAY);
    sp <= 16'd500;
    wt(5);
    chk("freq_out", fout, 32'd500);
    $display("test skip band done");
    wr(OFS_CTRL, 32'h23, RESP_OKAY);
    for (int i = 1; i < 7; i++) begin
      flt_q <= 1;
      wt(8);
      chk("dout", dout, 1);
      chk("run", run_o, 0);
      flt_q <= 0;
      wt(8);
      rd(OFS_STATUS, (i < 6) ? 32'((i << 4) | 5) : 32'h5d, RESP_OKAY);
    end
    clr_q <= 1;
    wt(8);
    clr_q <= 0;
    wt(8);
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    chk("run", run_o, 0);
    wr(OFS_CTRL, 32'h13, RESP_OKAY);
    wt(8);
    chk("run", run_o, 1);
    $display("test restart done");
    rst_n_i <= 0;
    wt(4);
    rst_n_i <= 1;
    wt(10);
    chk("run", run_o, 0);
    rd(OFS_CTRL, 32'h8, RESP_OKAY);
    run_q <= 0;
    wt(8);
    run_q <= 1;
    wt(8);
    chk("run", run_o, 1);
    $display("test start mode done");
    stop_test();
  end
endmodule
`default_nettype wire
